/* shared/cwd_pkg.sv */
// Constants, types and field layout of the configuration word decoder.
// Assumes a 10 MHz core clock and a classic Wishbone master with 32-bit data.
package cwd_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int POWERUP_DELAY_TIMER_TIME_MS = 72;
	localparam int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_TIME_MS * (CLK_HZ / 1000);
	localparam int OST_CYCLES = 1024;
	localparam int WDT_TICKS = 256;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [15:0] CFG_WORD_INDEX = 16'h2007;
	localparam logic [15:0] CFG_WORD_ADDR = {CFG_WORD_INDEX[13:0], 2'b00};
	localparam logic [15:0] STATUS_ADDR = 16'h0000;
	localparam logic [15:0] CTRL_ADDR = 16'h0004;

	// ----------------------------------------
	// Configuration word layout
	// ----------------------------------------
	localparam int CFG_WIDTH = 14;
	localparam logic [13:0] CFG_RESET = 14'h3fff;
	localparam logic [13:0] CFG_UNIMPL_MASK = 14'h3fa0;
	localparam int BROWNOUT_BIT = 6;
	localparam int CODE_PROTECT_BIT = 4;
	localparam int POWERUP_N_BIT = 3;
	localparam int WATCHDOG_BIT = 2;
	localparam int OSC_LO_BIT = 0;
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int CTRL_WDT_CLEAR_BIT = 1;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		LOW_POWER_CRYSTAL_MODE = 2'b00,
		STANDARD_CRYSTAL_MODE = 2'b01,
		HIGH_SPEED_CRYSTAL_MODE = 2'b10,
		RC_OSC_MODE = 2'b11
	} cwd_osc_type;

	typedef enum logic [4:0] {
		ST_POWERUP_DELAY = 5'b00001,
		ST_OSC_STARTUP = 5'b00010,
		ST_RUN = 5'b00100,
		ST_SLEEP = 5'b01000,
		ST_HOLD = 5'b10000
	} cwd_state_type;

	typedef struct packed {
		logic codeProtect;
		logic brownoutResetEnable;
		logic powerupDelayEnable;
		logic watchdogEnable;
		cwd_osc_type oscSelect;
	} cwd_cfg_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [15:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} cwd_wbreq_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} cwd_wbrsp_type;

endpackage

/* hw/cwd_config_word_decode.sv */
// Configuration word store, decoder and reset/sleep sequencer.
// Assumes inputs synchronous to mclk; wdtTick is a one-cycle pulse per watchdog oscillator period.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cwd_config_word_decode #(
	parameter int POWERUP_DELAY_TIMER_CYCLES = cwd_pkg::POWERUP_DELAY_TIMER_CYCLES,
	parameter int OST_CYCLES = cwd_pkg::OST_CYCLES,
	parameter int WDT_TICKS = cwd_pkg::WDT_TICKS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Wishbone slave
	input wire cwd_pkg::cwd_wbreq_type wbReq,
	output cwd_pkg::cwd_wbrsp_type wbRsp,
	// Device pins and events
	input wire logic progMode,
	input wire logic extResetN,
	input wire logic wdtTick,
	input wire logic irqPending,
	// Core side
	output logic coreReset,
	output logic sleepActive,
	output cwd_pkg::cwd_cfg_type cfgOut
);
	import cwd_pkg::*;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (POWERUP_DELAY_TIMER_CYCLES < 2 || OST_CYCLES < 2 || WDT_TICKS < 2) begin : g_badParam
		$error("cwd_config_word_decode: counts must be at least 2");
	end

	localparam int CNT_MAX = (POWERUP_DELAY_TIMER_CYCLES > OST_CYCLES) ? POWERUP_DELAY_TIMER_CYCLES : OST_CYCLES;
	localparam int CNT_W = $clog2(CNT_MAX);
	localparam int WDT_W = $clog2(WDT_TICKS);
	localparam logic [CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1);
	localparam logic [CNT_W-1:0] OST_LAST = CNT_W'(OST_CYCLES - 1);
	localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_TICKS - 1);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic ackReg;
	logic [31:0] rdatReg;
	logic [13:0] cfgReg;
	logic [13:0] cfgNext;
	cwd_state_type stateReg;
	cwd_state_type stateNext;
	logic [CNT_W-1:0] delayCntReg;
	logic [CNT_W-1:0] delayCntNext;
	logic [WDT_W-1:0] wdtCntReg;
	logic [WDT_W-1:0] wdtCntNext;
	cwd_cfg_type cfgDec;

	wire busReq = wbReq.cyc && wbReq.stb && !ackReg;
	wire hitCfg = wbReq.adr == CFG_WORD_ADDR;
	wire cfgOpen = hitCfg && progMode;
	wire hitStatus = wbReq.adr == STATUS_ADDR;
	wire hitCtrl = wbReq.adr == CTRL_ADDR;
	wire cfgWrite = busReq && wbReq.we && cfgOpen;
	wire ctrlWrite = busReq && wbReq.we && hitCtrl;
	wire sleepCmd = ctrlWrite && wbReq.sel[0] && wbReq.dat[CTRL_SLEEP_BIT];
	wire wdtClearCmd = ctrlWrite && wbReq.sel[0] && wbReq.dat[CTRL_WDT_CLEAR_BIT];

	// Byte lanes: low lane holds bits 7:0, next lane bits 13:8
	wire [13:0] laneMask = {{6{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
	wire [13:0] cfgMerged = (cfgReg & ~laneMask) | (wbReq.dat[13:0] & laneMask);
	// Unimplemented positions are forced high whatever the programmer writes
	assign cfgNext = cfgWrite ? (cfgMerged | CFG_UNIMPL_MASK) : cfgReg;

	wire [31:0] statusWord = {20'h0_0000, progMode, cfgDec, stateReg};
	// A closed config location answers like an unmapped one: zero data, no effect
	wire [31:0] rdatNext = cfgOpen ? {18'h0_0000, cfgReg} :
		hitStatus ? statusWord : READ_ZERO;

	// ----------------------------------------
	// Configuration decode
	// ----------------------------------------
	// Programmed bits read as zero, so active-low fields invert here
	assign cfgDec.oscSelect = cwd_osc_type'(cfgReg[OSC_LO_BIT +: 2]);
	assign cfgDec.watchdogEnable = cfgReg[WATCHDOG_BIT];
	assign cfgDec.powerupDelayEnable = !cfgReg[POWERUP_N_BIT];
	assign cfgDec.codeProtect = !cfgReg[CODE_PROTECT_BIT];
	assign cfgDec.brownoutResetEnable = cfgReg[BROWNOUT_BIT];
	wire crystalMode = cfgDec.oscSelect != RC_OSC_MODE;

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	// Ticks come from the watchdog's own oscillator, not from mclk
	wire wdtLive = cfgDec.watchdogEnable && (stateReg == ST_RUN || stateReg == ST_SLEEP);
	wire wdtTimeout = wdtLive && wdtTick && wdtCntReg == WDT_LAST;
	wire wdtClear = !wdtLive || wdtClearCmd || wdtTimeout || sleepCmd;
	assign wdtCntNext = wdtClear ? '0 : (wdtTick ? wdtCntReg + 1'b1 : wdtCntReg);

	// ----------------------------------------
	// Reset and sleep sequencer
	// ----------------------------------------
	wire pwrtDone = !cfgDec.powerupDelayEnable || delayCntReg == POWERUP_DELAY_TIMER_LAST;
	wire ostDone = delayCntReg == OST_LAST;
	wire wakeEvent = wdtTimeout || irqPending;
	cwd_state_type wakeTarget;
	assign wakeTarget = crystalMode ? ST_OSC_STARTUP : ST_RUN;

	always_comb begin
		stateNext = stateReg;
		case (stateReg)
			ST_POWERUP_DELAY: begin
				if (pwrtDone) begin
					stateNext = wakeTarget;
				end
			end
			ST_OSC_STARTUP: begin
				if (ostDone) begin
					stateNext = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!extResetN || wdtTimeout) begin
					stateNext = ST_HOLD;
				end else if (sleepCmd) begin
					stateNext = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!extResetN) begin
					stateNext = ST_HOLD;
				end else if (wakeEvent) begin
					stateNext = wakeTarget;
				end
			end
			ST_HOLD: begin
				// External and watchdog resets skip the power-up delay
				if (extResetN) begin
					stateNext = ST_RUN;
				end
			end
			default: begin
				stateNext = ST_POWERUP_DELAY;
			end
		endcase
	end

	assign delayCntNext = (stateNext != stateReg) ? '0 : delayCntReg + 1'b1;
	wire holdNext = stateNext == ST_POWERUP_DELAY || stateNext == ST_OSC_STARTUP || stateNext == ST_HOLD;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Limitation: nrst models power-on, so the stored word returns to its erased value
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cfgReg <= CFG_RESET;
			stateReg <= ST_POWERUP_DELAY;
			delayCntReg <= '0;
			wdtCntReg <= '0;
		end else begin
			cfgReg <= cfgNext;
			stateReg <= stateNext;
			delayCntReg <= delayCntNext;
			wdtCntReg <= wdtCntNext;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ackReg <= 1'b0;
			rdatReg <= READ_ZERO;
			coreReset <= 1'b1;
			sleepActive <= 1'b0;
			cfgOut <= '0;
		end else begin
			ackReg <= busReq;
			rdatReg <= rdatNext;
			coreReset <= holdNext;
			sleepActive <= stateNext == ST_SLEEP;
			cfgOut <= cfgDec;
		end
	end

	assign wbRsp.ack = ackReg;
	assign wbRsp.dat = rdatReg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence cfgReadReq;
		busReq && cfgOpen && !wbReq.we;
	endsequence
	sequence ostFinish;
		stateReg == ST_OSC_STARTUP && ostDone && extResetN;
	endsequence
	sequence runReleased;
		stateReg == ST_RUN ##0 !coreReset;
	endsequence

	a_cfg_polarity_decode: assert property ($past(nrst) |-> cfgOut.powerupDelayEnable == !$past(cfgReg[POWERUP_N_BIT]))
		else $error("power-up enable polarity wrong");
	a_cfg_word_read: assert property (cfgReadReq |=> wbRsp.ack && wbRsp.dat == {18'h0_0000, $past(cfgReg)})
		else $error("config word read mismatch");
	a_cfg_prog_only: assert property ((busReq && hitCfg && !progMode) |=> $stable(cfgReg) && wbRsp.dat == READ_ZERO)
		else $error("config word reached outside programming mode");
	a_unimpl_read_one: assert property ((cfgReg & CFG_UNIMPL_MASK) == CFG_UNIMPL_MASK)
		else $error("unimplemented bit not one");
	a_wdt_gated_off: assert property (!cfgReg[WATCHDOG_BIT] |=> wdtCntReg == '0)
		else $error("watchdog counting while disabled");
	a_powerup_delay_timer_hold_reset: assert property ((stateReg == ST_POWERUP_DELAY && cfgDec.powerupDelayEnable
		&& delayCntReg != POWERUP_DELAY_TIMER_LAST) |=> stateReg == ST_POWERUP_DELAY && coreReset)
		else $error("power-up delay released early");
	a_ost_release: assert property (ostFinish |=> runReleased)
		else $error("start-up timer release wrong");
	a_sleep_wake_irq: assert property ((stateReg == ST_SLEEP && irqPending && extResetN) |=> stateReg != ST_SLEEP)
		else $error("interrupt did not wake from sleep");
	a_osc_mode_decode: assert property ($past(nrst) |-> cfgOut.oscSelect == $past(cfgReg[1:0]))
		else $error("oscillator select decode wrong");
	a_cfg_bit_decode: assert property ($past(nrst) |-> cfgOut.brownoutResetEnable == $past(cfgReg[BROWNOUT_BIT])
		&& cfgOut.codeProtect == !$past(cfgReg[CODE_PROTECT_BIT]))
		else $error("brown-out or protect decode wrong");

endmodule // cwd_config_word_decode
`default_nettype wire

/* verification/cwd_programmer.sv */
// Programmer model: drives the configuration bus as a classic Wishbone master.
// Assumes the bench calls its tasks from the mclk domain only.
`timescale 1ns/100ps
`default_nettype none
module cwd_programmer (
	// Clock
	input wire logic mclk,
	// Bus side
	output var cwd_pkg::cwd_wbreq_type wbReq,
	output var logic progMode,
	input wire cwd_pkg::cwd_wbrsp_type wbRsp
);
	import cwd_pkg::*;
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	initial begin
		wbReq = '0;
		progMode = 1'b0;
	end
	task automatic setProg(input logic on);
		@(posedge mclk);
		progMode <= on;
	endtask
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r, output bit to);
		to = 1'b1;
		r = '0;
		@(posedge mclk);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h3, dat: d};
		for (int i = 0; i < 20; i++) begin
			@(posedge mclk);
			if (wbRsp.ack === 1'b1) begin
				r = wbRsp.dat;
				to = 1'b0;
				break;
			end
		end
		// Released lines must not keep the last value
		wbReq <= '{cyc: 1'b0, stb: 1'b0, we: ~w, adr: ~a, sel: 4'h0, dat: ~d};
	endtask
endmodule // cwd_programmer
`default_nettype wire

/* verification/tb.sv */
// Bench for the configuration word decoder: sequencer, wake sources and word decode.
// Assumes the programmer model owns the bus; timer counts are shortened.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import cwd_pkg::*;
	localparam logic [15:0] UNMAPPED_ADDR = 16'h0100;
	logic mclk, nrst, extResetN, wdtTick, irqPending, progMode, coreReset, sleepActive;
	bit to;
	cwd_wbreq_type wbReq;
	cwd_wbrsp_type wbRsp;
	cwd_cfg_type cfgOut;
	logic [31:0] rd;
	logic [13:0] word;
	logic [13:0] pend[$];
	int num_errors, compares, seed;
	always #50 mclk = ~mclk;
	cwd_config_word_decode #(.POWERUP_DELAY_TIMER_CYCLES(20), .OST_CYCLES(8), .WDT_TICKS(4)) cwd_config_word_decode_inst (
		.mclk(mclk), .nrst(nrst), .wbReq(wbReq), .wbRsp(wbRsp), .progMode(progMode), .extResetN(extResetN),
		.wdtTick(wdtTick), .irqPending(irqPending), .coreReset(coreReset), .sleepActive(sleepActive), .cfgOut(cfgOut));
	cwd_programmer cwd_programmer_inst (.mclk(mclk), .wbReq(wbReq), .progMode(progMode), .wbRsp(wbRsp));
	// ----------------------------------------
	// Model and helpers
	// ----------------------------------------
	function automatic logic [5:0] model(input logic [13:0] w);
		return {~w[4], w[6], ~w[3], w[2], w[1:0]};
	endfunction
	task automatic end_of_test;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		cwd_programmer_inst.xfer(w, a, d, rd, to);
		if (to) begin
			num_errors++;
			end_of_test();
		end
	endtask
	// Bounded wait on coreReset (s=0) or sleepActive (s=1)
	task automatic waitv(input bit s, input logic v);
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			if ((s ? sleepActive : coreReset) === v) return;
		end
		num_errors++;
		end_of_test();
	endtask
	task automatic tick;
		repeat (4) begin
			@(posedge mclk);
			wdtTick <= 1'b1;
			@(posedge mclk);
			wdtTick <= 1'b0;
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		extResetN = 1'b1;
		wdtTick = 1'b0;
		irqPending = 1'b0;
		seed = 61;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		waitv(1'b0, 1'b0);
		chk(32'(cfgOut), 32'(model(CFG_RESET)));
		tick();
		waitv(1'b0, 1'b1);
		waitv(1'b0, 1'b0);
		// Each pass enters sleep, then wakes by irq, external reset, watchdog
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, CTRL_ADDR, 32'h0000_0001);
			waitv(1'b1, 1'b1);
			if (k == 0) irqPending <= 1'b1;
			if (k == 1) extResetN <= 1'b0;
			if (k == 2) tick();
			waitv(1'b1, 1'b0);
			irqPending <= 1'b0;
			extResetN <= 1'b1;
			waitv(1'b0, 1'b0);
		end
		$display("test sequencer done");
		bus(1'b0, CFG_WORD_ADDR, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		bus(1'b1, CFG_WORD_ADDR, 32'h0000_0000);
		cwd_programmer_inst.setProg(1'b1);
		bus(1'b0, CFG_WORD_ADDR, 32'h0000_0000);
		chk(rd, 32'(CFG_RESET));
		bus(1'b0, UNMAPPED_ADDR, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		for (int i = 0; i < 12; i++) begin
			word = 14'($random(seed));
			word[1:0] = 2'(i);
			pend.push_back(word | CFG_UNIMPL_MASK);
			bus(1'b1, CFG_WORD_ADDR, {18'h0, word});
			bus(1'b0, CFG_WORD_ADDR, 32'h0000_0000);
			chk(rd, 32'(pend[0]));
			chk(32'(cfgOut), 32'(model(pend.pop_front())));
		end
		// Status shows programming mode, decoded word and the run state
		bus(1'b0, STATUS_ADDR, 32'h0000_0000);
		chk(rd, 32'({1'b1, model(word | CFG_UNIMPL_MASK), ST_RUN}));
		$display("test config word done");
		// Crystal mode: wake from sleep must pass through the start-up timer
		bus(1'b1, CFG_WORD_ADDR, 32'h0000_3ffd);
		bus(1'b1, CTRL_ADDR, 32'h0000_0001);
		waitv(1'b1, 1'b1);
		irqPending <= 1'b1;
		waitv(1'b1, 1'b0);
		irqPending <= 1'b0;
		chk(32'(coreReset), 32'h0000_0001);
		waitv(1'b0, 1'b0);
		$display("test crystal wake done");
		end_of_test();
	end
endmodule // tb
`default_nettype wire
